// file: src/core_data_memory_map.sv
// data memory address decoder, core registers and stack pointer
//
// Functional notes
// - 0x00-0x1F hold four eight-register banks
// - one bank active, chosen by status bits
// - indirect pointer is bank register zero/one
// - 0x20-0x2F reachable as bytes and bits
// - bit address 8k+n maps byte 0x20+k
// - bit or byte chosen by access kind
// - push writes at pointer+1, then increments
// - stack pointer resets to 0x07
// - stack may use all 256 bytes
// - stack pointer readable/writable at 0x81
// - direct 0x80-0xFF goes to register space
// - register bits only at 0 or 8
// - indirect above 0x7F uses upper ram
`timescale 1ns/100ps
`include "mem_map_cfg.svh"
module core_data_memory_map (
	// clocking
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic                    ce,
	// sequencer side
	input  wire mem_map_pkg::req_t       req,
	output mem_map_pkg::rsp_t            rsp,
	output logic                         req_ready,
	// peripheral register space
	output mem_map_pkg::ext_req_t        ext,
	input  wire logic [7:0]              ext_rdata,
	// core registers for the datapath
	output mem_map_pkg::core_regs_t      regs
);

	// ****************************************
	// helpers
	// ****************************************
	// address of working register idx in the given bank
	function automatic logic [7:0] reg_addr(input logic [1:0] bank, input logic [2:0] idx);
		reg_addr = {3'h0, bank, idx};
	endfunction

	// register held inside the core
	function automatic logic core_hit(input logic [7:0] a);
		core_hit = (a == `ADDR_STACK_TOP) || (a == `ADDR_DPTR_LO) || (a == `ADDR_DPTR_HI)
			|| (a == `ADDR_STATUS) || (a == `ADDR_WORK) || (a == `ADDR_AUX);
	endfunction

	// ****************************************
	// state and decode signals
	// ****************************************
	mem_map_pkg::map_state_t s_r;       // registered state
	mem_map_pkg::map_state_t s_nxt;     // next state
	logic [1:0]              bank;      // active bank number
	logic [7:0]              ra_a;      // pointer lookup address
	logic [7:0]              rd_a;      // pointer value
	logic [7:0]              tgt;       // decoded target address
	logic [7:0]              rd_b;      // ram byte at target
	logic                    to_sfr;    // target is register space
	logic [2:0]              bpos;      // bit inside target byte
	logic [7:0]              cur;       // current byte at target
	logic [7:0]              newb;      // byte to write back
	logic                    take;      // request accepted
	logic                    ram_we;    // ram write strobe
	logic [7:0]              ram_wa;    // ram write address

	assign take = ce && req.valid && (s_r.fsm == mem_map_pkg::ST_IDLE);

	// ****************************************
	// address decode
	// ****************************************
	// target, space and bit position from the access kind
	always_comb begin
		bank   = {s_r.regs.status_word[`BANK_HI_BIT], s_r.regs.status_word[`BANK_LO_BIT]};
		ra_a   = reg_addr(bank, {2'h0, req.addr[0]});
		tgt    = req.addr;
		to_sfr = 1'b0;
		bpos   = 3'h0;
		unique case (req.mode)
			mem_map_pkg::ACC_DIRECT: begin
				// upper direct half is register space
				to_sfr = req.addr[7];
			end
			mem_map_pkg::ACC_INDIRECT: begin
				tgt = rd_a;
			end
			mem_map_pkg::ACC_REG: begin
				tgt = reg_addr(bank, req.addr[2:0]);
			end
			mem_map_pkg::ACC_BIT: begin
				// bit area bytes also bit addressable
				// high bit space only on x0/x8 bytes
				to_sfr = req.addr[7];
				bpos   = req.addr[2:0];
				tgt    = req.addr[7] ? {req.addr[7:3], 3'h0}
					: (`BITBYTE_BASE | {4'h0, req.addr[6:3]});
			end
			mem_map_pkg::ACC_PUSH: begin
				// push lands one above the pointer
				// pointer wraps over the whole ram
				tgt = s_r.regs.stack_top_pointer + 8'h01;
			end
			mem_map_pkg::ACC_POP: begin
				tgt = s_r.regs.stack_top_pointer;
			end
			default: begin
				tgt = req.addr;
			end
		endcase
	end

	// ****************************************
	// ram
	// ****************************************
	data_ram #(
		.AW (8),
		.DW (8)
	) u_ram (
		.clock (clock),
		.ce    (ce),
		.we    (ram_we),
		.wa    (ram_wa),
		.wd    (newb),
		.ra_a  (ra_a),
		.rd_a  (rd_a),
		.ra_b  (tgt),
		.rd_b  (rd_b)
	);

	// ****************************************
	// next state
	// ****************************************
	// one access per cycle; external reads wait one extra cycle
	always_comb begin
		s_nxt           = s_r;
		s_nxt.rsp.valid = 1'b0;
		s_nxt.ext.valid = 1'b0;
		ram_we          = 1'b0;
		ram_wa          = tgt;
		// current byte, from core register or ram
		unique case (tgt)
			`ADDR_STACK_TOP: cur = s_r.regs.stack_top_pointer;
			`ADDR_DPTR_LO:   cur = s_r.regs.data_pointer_low_byte;
			`ADDR_DPTR_HI:   cur = s_r.regs.data_pointer_high_byte;
			`ADDR_STATUS:    cur = s_r.regs.status_word;
			`ADDR_WORK:      cur = s_r.regs.main_working_register;
			`ADDR_AUX:       cur = s_r.regs.multiply_aux_register;
			default:   cur = rd_b;
		endcase
		if (!to_sfr) begin
			cur = rd_b;
		end
		// bit merge only for bit access kind
		newb = req.wdata;
		if (req.mode == mem_map_pkg::ACC_BIT) begin
			newb       = cur;
			newb[bpos] = req.wdata[0];
		end
		unique case (s_r.fsm)
			mem_map_pkg::ST_IDLE: begin
				if (take && to_sfr && !core_hit(tgt)) begin
					// peripheral register: forward, never ram
					s_nxt.ext.valid = 1'b1;
					s_nxt.ext.write = req.write;
					s_nxt.ext.addr  = tgt;
					s_nxt.ext.wdata = req.mode == mem_map_pkg::ACC_BIT
						? {8{req.wdata[0]}} : req.wdata;
					s_nxt.ext.wmask = req.mode == mem_map_pkg::ACC_BIT
						? (8'h01 << bpos) : `FULL_MASK;
					s_nxt.bpos      = bpos;
					s_nxt.bitop     = req.mode == mem_map_pkg::ACC_BIT;
					if (req.write) begin
						s_nxt.rsp.valid = 1'b1;
					end else begin
						s_nxt.fsm = mem_map_pkg::ST_EXT;
					end
				end else if (take) begin
					s_nxt.rsp.valid = 1'b1;
					s_nxt.rsp.rdata = cur;
					s_nxt.rsp.rbit  = cur[bpos];
					if (req.mode == mem_map_pkg::ACC_PUSH) begin
						ram_we = 1'b1;
						s_nxt.regs.stack_top_pointer = tgt;
					end else if (req.mode == mem_map_pkg::ACC_POP) begin
						s_nxt.regs.stack_top_pointer = tgt - 8'h01;
					end else if (req.write && !to_sfr) begin
						ram_we = 1'b1;
					end else if (req.write) begin
						unique case (tgt)
							`ADDR_STACK_TOP: s_nxt.regs.stack_top_pointer      = newb;
							`ADDR_DPTR_LO:   s_nxt.regs.data_pointer_low_byte  = newb;
							`ADDR_DPTR_HI:   s_nxt.regs.data_pointer_high_byte = newb;
							`ADDR_STATUS:    s_nxt.regs.status_word            = newb;
							`ADDR_WORK:      s_nxt.regs.main_working_register  = newb;
							default:   s_nxt.regs.multiply_aux_register  = newb;
						endcase
					end
				end
			end
			mem_map_pkg::ST_EXT: begin
				// peripheral answered during the forwarded cycle
				s_nxt.rsp.valid = 1'b1;
				s_nxt.rsp.rdata = ext_rdata;
				s_nxt.rsp.rbit  = ext_rdata[s_r.bpos];
				s_nxt.fsm       = mem_map_pkg::ST_IDLE;
			end
		endcase
		s_nxt.ready = s_nxt.fsm == mem_map_pkg::ST_IDLE;
	end

	// ****************************************
	// state register
	// ****************************************
	// stack pointer reset value
	always_ff @(posedge clock) begin
		if (rst) begin
			s_r                        <= '0;
			s_r.fsm                    <= mem_map_pkg::ST_IDLE;
			s_r.ready                  <= 1'b1;
			s_r.regs.stack_top_pointer <= `STACK_RESET;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state flops
	assign rsp       = s_r.rsp;
	assign req_ready = s_r.ready;
	assign ext       = s_r.ext;
	assign regs      = s_r.regs;

	// ****************************************
	// checks
	// ****************************************
	property p_sp_reset;
		@(posedge clock) disable iff (rst)
		$fell(rst) |-> s_r.regs.stack_top_pointer == `STACK_RESET;
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("bad sp reset");

	property p_push_inc;
		@(posedge clock) disable iff (rst)
		take && req.mode == mem_map_pkg::ACC_PUSH
			|=> s_r.regs.stack_top_pointer == $past(s_r.regs.stack_top_pointer) + 8'h01;
	endproperty
	a_push_inc: assert property (p_push_inc) else $error("push no inc");

	property p_push_slot;
		@(posedge clock) disable iff (rst)
		take && req.mode == mem_map_pkg::ACC_PUSH
			|-> ram_we && ram_wa == s_r.regs.stack_top_pointer + 8'h01;
	endproperty
	a_push_slot: assert property (p_push_slot) else $error("push slot");

	property p_bank;
		@(posedge clock) disable iff (rst)
		take && req.mode == mem_map_pkg::ACC_REG
			|-> tgt == {3'h0, s_r.regs.status_word[`BANK_HI_BIT:`BANK_LO_BIT], req.addr[2:0]};
	endproperty
	a_bank: assert property (p_bank) else $error("bank decode");

	property p_ptr;
		@(posedge clock) disable iff (rst)
		take && req.mode == mem_map_pkg::ACC_INDIRECT
			|-> ra_a[7:1] == {3'h0, s_r.regs.status_word[`BANK_HI_BIT:`BANK_LO_BIT], 2'h0}
				&& tgt == rd_a;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer decode");

	property p_bitmap;
		@(posedge clock) disable iff (rst)
		take && req.mode == mem_map_pkg::ACC_BIT && !req.addr[7]
			|-> tgt == `BITBYTE_BASE + {4'h0, req.addr[6:3]} && bpos == req.addr[2:0];
	endproperty
	a_bitmap: assert property (p_bitmap) else $error("bit map");

	property p_direct_hi;
		@(posedge clock) disable iff (rst)
		take && req.mode == mem_map_pkg::ACC_DIRECT && req.addr[7] && req.write
			|-> !ram_we;
	endproperty
	a_direct_hi: assert property (p_direct_hi) else $error("direct hit ram");

	property p_ind_hi;
		@(posedge clock) disable iff (rst)
		take && req.mode == mem_map_pkg::ACC_INDIRECT && req.write
			|-> ram_we ##1 !s_r.ext.valid;
	endproperty
	a_ind_hi: assert property (p_ind_hi) else $error("indirect not ram");

	property p_sfr_bit;
		@(posedge clock) disable iff (rst)
		s_r.ext.valid && s_r.ext.wmask != `FULL_MASK |-> s_r.ext.addr[2:0] == 3'h0;
	endproperty
	a_sfr_bit: assert property (p_sfr_bit) else $error("bit on byte reg");

	property p_sp_read;
		@(posedge clock) disable iff (rst)
		take && req.mode == mem_map_pkg::ACC_DIRECT && !req.write
			&& req.addr == `ADDR_STACK_TOP
			|=> s_r.rsp.valid && s_r.rsp.rdata == $past(s_r.regs.stack_top_pointer);
	endproperty
	a_sp_read: assert property (p_sp_read) else $error("sp read");

endmodule

// file: src/mem_map_cfg.svh
// address constants and reset values of the data memory map
`ifndef MEM_MAP_CFG_SVH
`define MEM_MAP_CFG_SVH

// ****************************************
// core special function register offsets
// ****************************************
`define ADDR_STACK_TOP 8'h81
`define ADDR_DPTR_LO   8'h82
`define ADDR_DPTR_HI   8'h83
`define ADDR_STATUS    8'hd0
`define ADDR_WORK      8'he0
`define ADDR_AUX       8'hf0

// ****************************************
// reset values and field positions
// ****************************************
`define STACK_RESET    8'h07
`define REG_RESET      8'h00
`define BITBYTE_BASE   8'h20
`define BANK_LO_BIT    3
`define BANK_HI_BIT    4
`define FULL_MASK      8'hff

`endif

// file: src/mem_map_pkg.sv
// types shared by the data memory map, its peripheral model and bench
package mem_map_pkg;

	// ****************************************
	// access kinds from the sequencer
	// ****************************************
	typedef enum logic [2:0] {
		ACC_DIRECT,
		ACC_INDIRECT,
		ACC_REG,
		ACC_BIT,
		ACC_PUSH,
		ACC_POP
	} acc_mode_t;

	typedef enum logic {ST_IDLE, ST_EXT} map_fsm_t;

	// request from the sequencer
	typedef struct packed {
		logic       valid;
		acc_mode_t  mode;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} req_t;

	// answer to the sequencer
	typedef struct packed {
		logic       valid;
		logic [7:0] rdata;
		logic       rbit;
	} rsp_t;

	// request to the peripheral register space
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] wmask;
	} ext_req_t;

	// registers held by the core itself
	typedef struct packed {
		logic [7:0] stack_top_pointer;
		logic [7:0] data_pointer_low_byte;
		logic [7:0] data_pointer_high_byte;
		logic [7:0] status_word;
		logic [7:0] main_working_register;
		logic [7:0] multiply_aux_register;
	} core_regs_t;

	// whole state of the map
	typedef struct packed {
		map_fsm_t   fsm;
		logic       ready;
		logic [2:0] bpos;
		logic       bitop;
		core_regs_t regs;
		rsp_t       rsp;
		ext_req_t   ext;
	} map_state_t;

endpackage

// file: src/data_ram.sv
// 256 byte internal data ram, one write and two read ports
`timescale 1ns/100ps
module data_ram #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// clocking
	input  wire logic          clock,
	input  wire logic          ce,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] wa,
	input  wire logic [DW-1:0] wd,
	// read ports, combinational
	input  wire logic [AW-1:0] ra_a,
	output logic      [DW-1:0] rd_a,
	input  wire logic [AW-1:0] ra_b,
	output logic      [DW-1:0] rd_b
);

	// ****************************************
	// storage
	// ****************************************
	// no reset: ram contents are undefined after reset
	logic [DW-1:0] mem [2**AW];

	// write on the edge, frozen while ce is low
	always_ff @(posedge clock) begin
		if (ce && we) begin
			mem[wa] <= wd;
		end
	end

	// asynchronous reads allow the pointer chain in one cycle
	always_comb begin
		rd_a = mem[ra_a];
		rd_b = mem[ra_b];
	end

endmodule

// file: sim/periph_model.sv
// behavioural model of the peripheral register space behind the map
`timescale 1ns/100ps
module periph_model (
	// clocking
	input  wire logic                  clock,
	// register space access
	input  wire mem_map_pkg::ext_req_t ext,
	output logic [7:0]                 ext_rdata
);
	logic [7:0] space [256]; // register images
	logic [7:0] last_r;      // last byte seen on the data lines

	// known start pattern so reads can be predicted
	initial begin
		for (int i = 0; i < 256; i++) begin
			space[i] = 8'(i) ^ 8'h3c;
		end
		last_r = 8'h00;
	end

	// data only in the access cycle, inverted junk otherwise
	always_comb begin
		ext_rdata = ext.valid ? space[ext.addr] : ~last_r;
	end

	// masked write keeps bits outside the mask
	always @(posedge clock) begin
		if (ext.valid) begin
			last_r <= ext.write ? ext.wdata : space[ext.addr];
			if (ext.write) begin
				space[ext.addr] <= (space[ext.addr] & ~ext.wmask) | (ext.wdata & ext.wmask);
			end
		end
	end
endmodule

// file: sim/tb_top.sv
// self-checking bench for the data memory map
`timescale 1ns/100ps
module tb_top;
	logic                     clock;        // core clock
	logic                     rst;          // sync reset
	logic                     ce;           // clock enable
	mem_map_pkg::req_t        req;          // sequencer request
	mem_map_pkg::rsp_t        rsp;          // answer
	logic                     req_ready;    // request may be taken
	mem_map_pkg::ext_req_t    ext;          // register space access
	logic [7:0]               ext_rdata;    // register space data
	mem_map_pkg::core_regs_t  regs;         // core registers
	logic [7:0]               rd;           // last read byte
	logic                     rb;           // last read bit
	int                       errors;       // mismatches
	int                       total_checks; // comparisons

	core_data_memory_map uut (
		.clock     (clock),
		.rst       (rst),
		.ce        (ce),
		.req       (req),
		.rsp       (rsp),
		.req_ready (req_ready),
		.ext       (ext),
		.ext_rdata (ext_rdata),
		.regs      (regs)
	);

	periph_model far_side (
		.clock     (clock),
		.ext       (ext),
		.ext_rdata (ext_rdata)
	);

	// 4 ns period
	always #2 clock = ~clock;

	// ****************************************
	// compare and access tasks
	// ****************************************
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	// one request, held to the taking edge, then wait for the answer
	task automatic access(input mem_map_pkg::acc_mode_t m, input logic w,
			input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		req <= '{valid: 1'b1, mode: m, write: w, addr: a, wdata: d};
		@(posedge clock);
		req.valid <= 1'b0;
		for (n = 0; n < 8; n++) begin
			@(negedge clock);
			if (rsp.valid === 1'b1) begin
				break;
			end
		end
		chk_bit("answer pulse", 1'b1, rsp.valid);
		rd = rsp.rdata;
		rb = rsp.rbit;
	endtask

	task automatic dwr(input logic [7:0] a, input logic [7:0] d);
		access(mem_map_pkg::ACC_DIRECT, 1'b1, a, d);
	endtask

	task automatic drd(input logic [7:0] a);
		access(mem_map_pkg::ACC_DIRECT, 1'b0, a, 8'h00);
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// hang guard, far beyond the hundred or so cycles needed
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		test_done();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		req = '0;
		errors = 0;
		total_checks = 0;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk_byte("stack reset", 8'h07, regs.stack_top_pointer);
		chk_byte("status reset", 8'h00, regs.status_word);
		chk_bit("ready after reset", 1'b1, req_ready);
		drd(8'h81);
		chk_byte("stack read", 8'h07, rd);
		// each bank lands at bank*8
		for (int b = 0; b < 4; b++) begin
			dwr(8'hd0, 8'(b << 3));
			chk_byte("status", 8'(b << 3), regs.status_word);
			access(mem_map_pkg::ACC_REG, 1'b1, 8'h04, 8'h40 + 8'(b));
			drd(8'(b * 8 + 4));
			chk_byte("bank reg", 8'h40 + 8'(b), rd);
		end
		// pointer registers of bank three: register one into upper ram, register zero into 0x30
		access(mem_map_pkg::ACC_REG, 1'b1, 8'h01, 8'h88);
		access(mem_map_pkg::ACC_INDIRECT, 1'b1, 8'h01, 8'h5a);
		access(mem_map_pkg::ACC_INDIRECT, 1'b0, 8'h01, 8'h00);
		chk_byte("upper ram", 8'h5a, rd);
		drd(8'h88);
		chk_byte("register space", 8'hb4, rd);
		access(mem_map_pkg::ACC_REG, 1'b1, 8'h00, 8'h30);
		dwr(8'h30, 8'h66);
		access(mem_map_pkg::ACC_INDIRECT, 1'b0, 8'h00, 8'h00);
		chk_byte("pointer zero", 8'h66, rd);
		// bit area and bit numbering
		dwr(8'h2f, 8'h00);
		access(mem_map_pkg::ACC_BIT, 1'b1, 8'h7f, 8'h01);
		drd(8'h2f);
		chk_byte("bit 7f byte", 8'h80, rd);
		dwr(8'h07, 8'h00);
		dwr(8'h20, 8'h80);
		access(mem_map_pkg::ACC_BIT, 1'b0, 8'h07, 8'h00);
		chk_bit("bit 07", 1'b1, rb);
		access(mem_map_pkg::ACC_BIT, 1'b0, 8'h06, 8'h00);
		chk_bit("bit 06", 1'b0, rb);
		// bit access to register space and core registers
		access(mem_map_pkg::ACC_BIT, 1'b1, 8'h8b, 8'h01);
		drd(8'h88);
		chk_byte("register bit", 8'hbc, rd);
		access(mem_map_pkg::ACC_BIT, 1'b1, 8'hd3, 8'h00);
		chk_byte("status bit", 8'h10, regs.status_word);
		// stack from reset value, then near the top of ram
		dwr(8'hd0, 8'h00);
		access(mem_map_pkg::ACC_PUSH, 1'b1, 8'h00, 8'ha5);
		chk_byte("push pointer", 8'h08, regs.stack_top_pointer);
		drd(8'h08);
		chk_byte("pushed byte", 8'ha5, rd);
		access(mem_map_pkg::ACC_POP, 1'b0, 8'h00, 8'h00);
		chk_byte("pop byte", 8'ha5, rd);
		chk_byte("pop pointer", 8'h07, regs.stack_top_pointer);
		dwr(8'h81, 8'hfe);
		drd(8'h81);
		chk_byte("stack write", 8'hfe, rd);
		access(mem_map_pkg::ACC_PUSH, 1'b1, 8'h00, 8'h3c);
		chk_byte("top pointer", 8'hff, regs.stack_top_pointer);
		access(mem_map_pkg::ACC_POP, 1'b0, 8'h00, 8'h00);
		chk_byte("top byte", 8'h3c, rd);
		// clock enable low: a standing push must not be taken
		@(posedge clock);
		ce <= 1'b0;
		req <= '{valid: 1'b1, mode: mem_map_pkg::ACC_PUSH, write: 1'b1, addr: 8'h00, wdata: 8'h11};
		repeat (3) @(posedge clock);
		@(negedge clock);
		chk_byte("frozen pointer", 8'hfe, regs.stack_top_pointer);
		chk_bit("frozen answer", 1'b0, rsp.valid);
		@(posedge clock);
		ce <= 1'b1;
		req.valid <= 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk_byte("pointer after freeze", 8'hfe, regs.stack_top_pointer);
		test_done();
	end
endmodule
